// ---- hdl/sacr_config_bank.v ----
// Functional notes
// RULE_01 - Four 8-bit registers, command access only.
// RULE_02 - Reset clears all registers to zero.
// RULE_03 - Power-down keeps register values.
// RULE_04 - Writes accepted anytime, even mid-conversion.
// RULE_05 - Register 0 bits 7:4 select input pair.
// RULE_06 - Host sets bypass, low gain for negative supply.
// RULE_07 - Register 0 bits 3:1 select gain.
// RULE_08 - Gains 8 to 128 keep amplifier on.
// RULE_09 - Register 0 bit 0 bypasses amplifier.
// RULE_10 - Register 1 bits 7:5 select data rate.
// RULE_11 - Normal mode rates 20 to 1000.
// RULE_12 - Duty and turbo mode rate tables.
// RULE_13 - Register 1 bits 4:3 operating mode.
// RULE_14 - Register 1 bit 2 continuous conversions.
// RULE_15 - Temperature mode overrides register 0. The bank's register 0 field outputs ignore the temperature bit.
// RULE_16 - Register 1 bit 0 fault currents.
// RULE_17 - Register 2 bits 7:6 reference select.
// RULE_18 - Filter bits apply at slowest rates.
// RULE_19 - Low-side switch follows start and power-down.
// RULE_20 - Register 2 bits 2:0 excitation current.
// RULE_21 - Register 3 routes both excitation currents.
// RULE_22 - Register 3 bit 1 ready signalling mode.
// RULE_23 - Host writes zero to register 3 bit 0.
`timescale 1ns/1ps
`include "sacr_map.vh"

// Configuration bank reached by the decoded register commands.
module sacr_config_bank (
  // Clock and reset.
  input wire i_sys_clk,
  input wire i_sys_rst,
  // Register command strobes from the command decoder.
  input wire i_register_write_command,
  input wire i_register_read_command,
  input wire [1:0] i_reg_index,
  input wire [7:0] i_wr_data,
  // Other command strobes.
  input wire i_start_sync_command,
  input wire i_power_down_command,
  // Conversion data ready event from the data path.
  input wire i_data_ready,
  // Read-back.
  output reg [7:0] o_rd_data,
  output reg o_rd_valid,
  // Raw register images.
  output wire [7:0] o_input_gain_config,
  output wire [7:0] o_rate_mode_config,
  output wire [7:0] o_reference_filter_excitation_config,
  output wire [7:0] o_current_routing_ready_config,
  // Effective analog controls.
  output wire [3:0] o_input_select,
  output wire [2:0] o_gain_code,
  output wire o_amplifier_enable,
  output wire o_amplifier_bypass,
  output wire [2:0] o_rate_code,
  output wire [1:0] o_op_mode,
  output wire o_continuous_select,
  output wire o_temperature_sense_enable,
  output wire o_fault_current_enable,
  output wire [1:0] o_reference_select,
  output wire [1:0] o_line_filter,
  output wire o_line_filter_active,
  output wire o_low_side_switch_auto,
  output wire o_low_side_switch_closed,
  output wire [2:0] o_excitation_current_level,
  output wire [2:0] o_first_current_route,
  output wire [2:0] o_second_current_route,
  output wire o_ready_on_data_out,
  output wire o_ready_to_pin,
  output wire o_ready_to_data_out,
  output wire o_powered_down,
  output wire o_config_changed,
  output wire o_config_code_unused
);

  reg powered_down_r;
  reg changed_r;
  wire [7:0] reg_val [0:3];
  wire [3:0] reg_wr;
  wire [2:0] gain_code;
  wire bypass_req;
  genvar gi;

  // Gains 1, 2 and 4 are the only ones that may run without the amplifier.
  function low_gain;
    input [2:0] code;
    begin
      low_gain = (code < `SACR_GAIN_8);
    end
  endfunction

  // Write decode; power-down does not gate writes, only analog state.
  assign reg_wr[0] = i_register_write_command &&
                     (i_reg_index == `SACR_IDX_INPUT_GAIN); // RULE_04
  assign reg_wr[1] = i_register_write_command &&
                     (i_reg_index == `SACR_IDX_RATE_MODE);
  assign reg_wr[2] = i_register_write_command &&
                     (i_reg_index == `SACR_IDX_REF_FILT_EXC);
  assign reg_wr[3] = i_register_write_command &&
                     (i_reg_index == `SACR_IDX_ROUTE_READY);

  // Four storage registers, cleared by reset and held in power-down.
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_reg
      sacr_reg8 u_reg (
        .i_sys_clk(i_sys_clk),
        .i_sys_rst(i_sys_rst),
        .i_wr_en(reg_wr[gi]),
        .i_wr_data(i_wr_data),
        .o_value(reg_val[gi])
      ); // RULE_01 RULE_02 RULE_03
    end
  endgenerate

  // Read-back answers in the cycle after the read strobe.
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_rd_data <= 8'h00;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_register_read_command;
      if (i_register_read_command) begin
        o_rd_data <= reg_val[i_reg_index]; // RULE_01
      end
    end
  end

  // Power-down state: entered by command, left by start/sync.
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      powered_down_r <= 1'b0;
    end else if (i_power_down_command) begin
      powered_down_r <= 1'b1;
    end else if (i_start_sync_command) begin
      powered_down_r <= 1'b0;
    end
  end

  // A write pulses a change flag so the data path restarts its filter.
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      changed_r <= 1'b0;
    end else begin
      changed_r <= i_register_write_command;
    end
  end

  assign o_input_gain_config = reg_val[0];
  assign o_rate_mode_config = reg_val[1];
  assign o_reference_filter_excitation_config = reg_val[2];
  assign o_current_routing_ready_config = reg_val[3];

  // Register 0 fields.
  assign o_input_select =
    reg_val[0][`SACR_INSEL_HI:`SACR_INSEL_LO]; // RULE_05
  assign gain_code = reg_val[0][`SACR_GAIN_HI:`SACR_GAIN_LO]; // RULE_07
  assign o_gain_code = gain_code;
  assign bypass_req = reg_val[0][`SACR_BYPASS_BIT]; // RULE_09
  // High gains force the amplifier on outside power-down, whatever the bypass bit says.
  assign o_amplifier_bypass = bypass_req && low_gain(gain_code); // RULE_08
  assign o_amplifier_enable = !o_amplifier_bypass &&
                              !powered_down_r; // RULE_09

  // Register 1 fields; rate meaning depends on mode in the data path.
  assign o_rate_code = reg_val[1][`SACR_RATE_HI:`SACR_RATE_LO]; // RULE_10
  assign o_op_mode = reg_val[1][`SACR_MODE_HI:`SACR_MODE_LO]; // RULE_13
  assign o_continuous_select = reg_val[1][`SACR_CONT_BIT]; // RULE_14
  assign o_temperature_sense_enable =
    reg_val[1][`SACR_TEMP_BIT]; // RULE_15
  assign o_fault_current_enable = reg_val[1][`SACR_FAULT_BIT] &&
                                  !powered_down_r; // RULE_16

  // Register 2 fields.
  assign o_reference_select =
    reg_val[2][`SACR_VREF_HI:`SACR_VREF_LO]; // RULE_17
  assign o_line_filter = reg_val[2][`SACR_FILT_HI:`SACR_FILT_LO];
  // The FIR choice only matters at the slowest normal and duty rates.
  assign o_line_filter_active =
    (o_rate_code == `SACR_RATE_20SPS) &&
    ((o_op_mode == `SACR_MODE_NORMAL) ||
     (o_op_mode == `SACR_MODE_DUTY)); // RULE_18 RULE_11 RULE_12
  assign o_low_side_switch_auto = reg_val[2][`SACR_SWITCH_BIT];
  // Excitation currents are forced off while powered down.
  assign o_excitation_current_level = powered_down_r ? 3'h0 :
    reg_val[2][`SACR_EXC_HI:`SACR_EXC_LO]; // RULE_20

  // Register 3 fields; bit 0 is stored but steers nothing.
  assign o_first_current_route =
    reg_val[3][`SACR_R1_HI:`SACR_R1_LO]; // RULE_21
  assign o_second_current_route =
    reg_val[3][`SACR_R2_HI:`SACR_R2_LO]; // RULE_21
  assign o_ready_on_data_out = reg_val[3][`SACR_RDYM_BIT]; // RULE_22
  assign o_ready_to_pin = i_data_ready;
  assign o_ready_to_data_out = i_data_ready &&
                               o_ready_on_data_out; // RULE_22

  // Low-side switch sequencing.
  sacr_low_switch u_switch (
    .i_sys_clk(i_sys_clk),
    .i_sys_rst(i_sys_rst),
    .i_auto_en(o_low_side_switch_auto),
    .i_start_sync(i_start_sync_command),
    .i_power_down(i_power_down_command),
    .o_closed(o_low_side_switch_closed)
  ); // RULE_19

  assign o_powered_down = powered_down_r;
  assign o_config_changed = changed_r;

  // Flags any code marked unused in the input, rate, mode, excitation and route fields.
  assign o_config_code_unused =
    (o_input_select == `SACR_INSEL_UNUSED) ||
    (o_rate_code == `SACR_RATE_UNUSED) ||
    (o_op_mode == `SACR_MODE_UNUSED) ||
    (reg_val[2][`SACR_EXC_HI:`SACR_EXC_LO] == `SACR_EXC_UNUSED) ||
    (o_first_current_route == `SACR_ROUTE_UNUSED) ||
    (o_second_current_route == `SACR_ROUTE_UNUSED);

endmodule

// ---- hdl/sacr_map.vh ----
`ifndef SACR_MAP_VH
`define SACR_MAP_VH

// Register indices of the configuration bank.
`define SACR_IDX_INPUT_GAIN 2'h0
`define SACR_IDX_RATE_MODE 2'h1
`define SACR_IDX_REF_FILT_EXC 2'h2
`define SACR_IDX_ROUTE_READY 2'h3

// Reset value shared by all four registers.
`define SACR_RESET_VAL 8'h00

// Register 0 field positions.
`define SACR_INSEL_HI 7
`define SACR_INSEL_LO 4
`define SACR_GAIN_HI 3
`define SACR_GAIN_LO 1
`define SACR_BYPASS_BIT 0

// Register 1 field positions.
`define SACR_RATE_HI 7
`define SACR_RATE_LO 5
`define SACR_MODE_HI 4
`define SACR_MODE_LO 3
`define SACR_CONT_BIT 2
`define SACR_TEMP_BIT 1
`define SACR_FAULT_BIT 0

// Register 2 field positions.
`define SACR_VREF_HI 7
`define SACR_VREF_LO 6
`define SACR_FILT_HI 5
`define SACR_FILT_LO 4
`define SACR_SWITCH_BIT 3
`define SACR_EXC_HI 2
`define SACR_EXC_LO 0

// Register 3 field positions.
`define SACR_R1_HI 7
`define SACR_R1_LO 5
`define SACR_R2_HI 4
`define SACR_R2_LO 2
`define SACR_RDYM_BIT 1

// Codes with special meaning.
`define SACR_INSEL_UNUSED 4'hf
`define SACR_GAIN_8 3'h3
`define SACR_RATE_UNUSED 3'h7
`define SACR_MODE_NORMAL 2'h0
`define SACR_MODE_DUTY 2'h1
`define SACR_MODE_TURBO 2'h2
`define SACR_MODE_UNUSED 2'h3
`define SACR_EXC_UNUSED 3'h1
`define SACR_ROUTE_UNUSED 3'h7
`define SACR_RATE_20SPS 3'h0

`endif

// ---- hdl/sacr_reg8.v ----
`timescale 1ns/1ps
`include "sacr_map.vh"

// One 8-bit configuration register with synchronous clear.
module sacr_reg8 (
  // Clock and reset.
  input wire i_sys_clk,
  input wire i_sys_rst,
  // Write port.
  input wire i_wr_en,
  input wire [7:0] i_wr_data,
  // Stored value.
  output reg [7:0] o_value
);

  // Power-down has no input here, so the value is always held.
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      o_value <= `SACR_RESET_VAL;
    end else if (i_wr_en) begin
      o_value <= i_wr_data;
    end
  end

endmodule

// ---- hdl/sacr_low_switch.v ----
`timescale 1ns/1ps
`include "sacr_map.vh"

// Low-side switch state: closes on start/sync, opens on power-down.
module sacr_low_switch (
  // Clock and reset.
  input wire i_sys_clk,
  input wire i_sys_rst,
  // Control.
  input wire i_auto_en,
  input wire i_start_sync,
  input wire i_power_down,
  // Switch drive.
  output reg o_closed
);

  // Power-down wins over a simultaneous start so the switch fails open.
  always @(posedge i_sys_clk) begin
    if (i_sys_rst || !i_auto_en) begin
      o_closed <= 1'b0;
    end else if (i_power_down) begin
      o_closed <= 1'b0;
    end else if (i_start_sync) begin
      o_closed <= 1'b1;
    end
  end

endmodule

// ---- verification/sacr_config_bank_chk.sv ----
`timescale 1ns/1ps

// Watches the bank's command side and its decoded field outputs.
module sacr_config_bank_chk (
  // Clock and reset.
  input wire i_sys_clk,
  input wire i_sys_rst,
  // Command strobes.
  input wire i_register_write_command,
  input wire i_register_read_command,
  input wire [1:0] i_reg_index,
  input wire [7:0] i_wr_data,
  input wire i_start_sync_command,
  input wire i_power_down_command,
  // Observed outputs.
  input wire [7:0] o_rd_data,
  input wire o_rd_valid,
  input wire [7:0] o_input_gain_config,
  input wire [7:0] o_reference_filter_excitation_config,
  input wire [3:0] o_input_select,
  input wire [2:0] o_gain_code,
  input wire o_amplifier_bypass,
  input wire o_low_side_switch_auto,
  input wire o_low_side_switch_closed,
  input wire o_powered_down,
  input wire [2:0] o_excitation_current_level
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);

  // A start without a competing power-down closes an armed switch.
  sequence s_start_armed;
    o_low_side_switch_auto && i_start_sync_command && !i_power_down_command;
  endsequence
  sequence s_closed;
    o_low_side_switch_closed && !o_powered_down;
  endsequence

  chk_reset_clear: assert property (disable iff (1'b0) i_sys_rst |=>
    o_input_gain_config == 8'h00 &&
    o_reference_filter_excitation_config == 8'h00)
    else $error("bank not cleared by reset");
  chk_read_old: assert property (i_register_read_command &&
    i_reg_index == 2'h2 |=> o_rd_valid &&
    o_rd_data == $past(o_reference_filter_excitation_config))
    else $error("read-back wrong");
  chk_valid_pulse: assert property (!i_register_read_command |=>
    !o_rd_valid)
    else $error("stray read valid");
  chk_write_takes: assert property (i_register_write_command &&
    i_reg_index == 2'h0 |=> o_input_gain_config == $past(i_wr_data))
    else $error("write not stored");
  chk_pd_holds: assert property (o_powered_down &&
    !i_register_write_command |=> $stable(o_input_gain_config) &&
    $stable(o_reference_filter_excitation_config))
    else $error("register moved in power-down");
  chk_bypass_gain: assert property (o_amplifier_bypass ==
    (o_input_gain_config[0] && o_gain_code < 3'h3))
    else $error("bypass wrong for gain");
  chk_field_map: assert property (
    o_input_select == o_input_gain_config[7:4] &&
    o_gain_code == o_input_gain_config[3:1])
    else $error("register 0 fields wrong");
  chk_switch_close: assert property (s_start_armed |=> s_closed)
    else $error("switch did not close");
  chk_switch_open: assert property (i_power_down_command |=>
    !o_low_side_switch_closed && o_powered_down)
    else $error("switch did not open");
  chk_exc_off: assert property (o_powered_down |->
    o_excitation_current_level == 3'h0)
    else $error("excitation on in power-down");
  chk_switch_idle: assert property (!o_low_side_switch_auto |=>
    !o_low_side_switch_closed)
    else $error("switch closed while not armed");
endmodule

bind sacr_config_bank sacr_config_bank_chk sacr_config_bank_chk_inst (
  .i_sys_clk, .i_sys_rst, .i_register_write_command,
  .i_register_read_command, .i_reg_index, .i_wr_data,
  .i_start_sync_command, .i_power_down_command, .o_rd_data, .o_rd_valid,
  .o_input_gain_config, .o_reference_filter_excitation_config,
  .o_input_select, .o_gain_code, .o_amplifier_bypass,
  .o_low_side_switch_auto, .o_low_side_switch_closed, .o_powered_down,
  .o_excitation_current_level
);

// ---- verification/sacr_host_model.sv ----
`timescale 1ns/1ps

// Host side: issues decoded command strobes on falling edges.
module sacr_host_model (
  // Clock.
  input wire i_sys_clk,
  // Read-back.
  input wire [7:0] i_rd_data,
  input wire i_rd_valid,
  // Strobes.
  output reg o_wr,
  output reg o_rd,
  output reg [1:0] o_idx,
  output reg [7:0] o_data,
  output reg o_start,
  output reg o_pd
);
  initial begin
    {o_wr, o_rd, o_idx, o_data, o_start, o_pd} = 14'h0;
  end

  // Byte write; an idle edge follows so strobes are never set twice at once.
  task wr(input [1:0] idx, input [7:0] d);
    reg [7:0] v;
    begin
      v = d;
      if (idx == 2'h3) v[0] = 1'b0;
      if (idx == 2'h0 && v[7:6] == 2'b10) begin
        v[0] = 1'b1;
        if (v[3:1] > 3'h2) v[3:1] = 3'h2;
      end
      @(negedge i_sys_clk);
      o_idx = idx;
      o_data = v;
      o_wr = 1'b1;
      @(negedge i_sys_clk);
      o_wr = 1'b0;
    end
  endtask

  // A missing valid pulse returns unknowns so the compare fails.
  task rd(input [1:0] idx, output [7:0] d);
    begin
      @(negedge i_sys_clk);
      o_idx = idx;
      o_rd = 1'b1;
      @(negedge i_sys_clk);
      o_rd = 1'b0;
      d = i_rd_valid ? i_rd_data : 8'hxx;
    end
  endtask

  task cmd(input s, input p);
    begin
      @(negedge i_sys_clk);
      o_start = s;
      o_pd = p;
      @(negedge i_sys_clk);
      o_start = 1'b0;
      o_pd = 1'b0;
    end
  endtask
endmodule

// ---- verification/sacr_config_bank_test.sv ----
`timescale 1ns/1ps

module sacr_config_bank_test;
  logic clk, rst, data_rdy, wr, rd, st, pd, rv, isw, ipd, aen, chg, unu, ibp;
  logic [1:0] idx, mode, vref, filt;
  logic [7:0] wd, rdd, d, img1, img3;
  logic [7:0] vals [4];
  logic [3:0] isel;
  logic [2:0] gain, rate, exc, r1, r2;
  logic cont_sel, temp_sel, fc, lfa, auto, rdym, rtp, rtd;
  int err_count, comparisons, i;

  sacr_host_model host (.i_sys_clk(clk), .i_rd_data(rdd), .i_rd_valid(rv),
    .o_wr(wr), .o_rd(rd), .o_idx(idx), .o_data(wd), .o_start(st), .o_pd(pd));

  sacr_config_bank sacr_config_bank_inst (.i_sys_clk(clk), .i_sys_rst(rst),
    .i_register_write_command(wr), .i_register_read_command(rd),
    .i_reg_index(idx), .i_wr_data(wd), .i_start_sync_command(st),
    .i_power_down_command(pd), .i_data_ready(data_rdy), .o_rd_data(rdd),
    .o_rd_valid(rv), .o_input_gain_config(), .o_rate_mode_config(img1),
    .o_reference_filter_excitation_config(),
    .o_current_routing_ready_config(img3), .o_input_select(isel),
    .o_gain_code(gain), .o_amplifier_enable(aen), .o_amplifier_bypass(ibp),
    .o_rate_code(rate), .o_op_mode(mode), .o_continuous_select(cont_sel),
    .o_temperature_sense_enable(temp_sel), .o_fault_current_enable(fc),
    .o_reference_select(vref), .o_line_filter(filt),
    .o_line_filter_active(lfa), .o_low_side_switch_auto(auto),
    .o_low_side_switch_closed(isw), .o_excitation_current_level(exc),
    .o_first_current_route(r1), .o_second_current_route(r2),
    .o_ready_on_data_out(rdym), .o_ready_to_pin(rtp),
    .o_ready_to_data_out(rtd), .o_powered_down(ipd), .o_config_changed(chg),
    .o_config_code_unused(unu));

  always #25 clk = ~clk;

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task results;
    $display("errors %0d compares %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Generous bound: the sequence needs well under a thousand cycles.
  initial begin
    #200000;
    err_count++;
    results;
  end

  initial begin
    clk = 1'b0;
    data_rdy = 1'b0;
    err_count = 0;
    comparisons = 0;
    rst = 1'b1;
    vals = '{8'h37, 8'hce, 8'h9d, 8'hb6};
    repeat (12) @(negedge clk);
    rst = 1'b0;
    for (i = 0; i < 4; i++) begin
      host.rd(i[1:0], d);
      chk(d, 8'h00);
    end
    // Writes go one after another with an idle cycle between strobes, then all four are read again.
    for (i = 0; i < 4; i++) host.wr(i[1:0], vals[i]);
    for (i = 0; i < 4; i++) begin
      host.rd(i[1:0], d);
      chk(d, vals[i]);
    end
    chk({isel, gain, ibp}, 8'h36);
    chk({7'h0, aen}, 8'h01);
    chk(img1, 8'hce);
    chk(img3, 8'hb6);
    chk({rate, mode, cont_sel, temp_sel, fc}, 8'hce);
    chk({vref, filt, auto, exc}, 8'h9d);
    chk({r1, r2, rdym, lfa}, 8'hb6);
    data_rdy = 1'b1;
    @(negedge clk);
    chk({6'h0, rtp, rtd}, 8'h03);
    host.wr(2'h0, 8'hbd);
    host.rd(2'h0, d);
    chk(d, 8'hb5);
    chk({7'h0, ibp}, 8'h01);
    chk({7'h0, aen}, 8'h00);
    host.wr(2'h1, 8'h01);
    chk({7'h0, chg}, 8'h01);
    chk({6'h0, lfa, fc}, 8'h03);
    host.cmd(1'b1, 1'b0);
    chk({6'h0, isw, ipd}, 8'h02);
    host.cmd(1'b0, 1'b1);
    chk({3'h0, isw, ipd, exc}, 8'h08);
    host.wr(2'h1, 8'h24);
    host.rd(2'h1, d);
    chk(d, 8'h24);
    chk({7'h0, chg}, 8'h00);
    host.rd(2'h2, d);
    chk(d, 8'h9d);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    host.rd(2'h2, d);
    chk(d, 8'h00);
    // Ready mode is back at its default, so only the dedicated pin flags.
    chk({6'h0, rtp, rtd}, 8'h02);
    host.wr(2'h1, 8'h10);
    chk({6'h0, lfa, unu}, 8'h00);
    host.wr(2'h1, 8'he0);
    chk({6'h0, lfa, unu}, 8'h01);
    results;
  end
endmodule
